// ---- dv/field_terminals.sv ----
// Field terminal model: drives the input terminals of the block
`timescale 1ns/1ps
`default_nettype none
module field_terminals (
	input  wire logic         clk_i,
	input  wire logic         load_i,
	input  wire logic [255:0] value_i,
	output var logic  [255:0] x_o
);
	// Terminals change just after a clock edge
	always_ff @(posedge clk_i) begin
		if (load_i) begin
			x_o <= value_i;
		end
	end
endmodule : field_terminals
`default_nettype wire

// ---- dv/test_scan_mem_ctrl.sv ----
// Self-checking bench for the scan memory retention block
`timescale 1ns/1ps
`default_nettype none
module test_scan_mem_ctrl;
	import scan_mem_pkg::*;
	logic           clk_i = 0, rst_i = 1, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0;
	logic           step_i = 0, end_i = 0, y_wr_i = 0, y_val_i = 0, load = 1;
	logic           wb_ack_o, exec_o, clr_valid_o;
	logic [7:0]     wb_adr_i = 8'h00;
	logic [3:0]     wb_sel_i = 4'h0;
	logic [11:0]    y_num_i = 12'h000;
	logic [31:0]    wb_dat_i = 32'h0, wb_dat_o, rd, seed = 32'h55F9E0B5;
	logic [15:0]    prog_addr_o, clr_addr_o, start;
	logic [255:0]   x_pins_i, y_pins_o, x_image_o, y_image_o, xnew = '0, y_model = '0;
	region_t        clr_region_o;
	int             fail_count = 0, n_compared = 0, n_clr = 0, n_scans = 0;
	localparam logic [31:0] WIN [6] = '{32'h1FFF1770, 32'h03FF0200, 32'h00000001,
		32'h01FF01C0, 32'h00FF0080, 32'h752F4E20};
	// Words of the default non-latched space: aux, step, timer, counter, wide, data, index
	localparam int NL_WORDS = 6000 + 1536 + 512 + 448 + 128 + 20000 + 10;
	scan_mem_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .x_pins_i(x_pins_i), .y_pins_o(y_pins_o),
		.x_image_o(x_image_o), .y_image_o(y_image_o), .exec_o(exec_o),
		.prog_addr_o(prog_addr_o), .step_i(step_i), .end_i(end_i), .y_wr_i(y_wr_i),
		.y_num_i(y_num_i), .y_val_i(y_val_i), .clr_valid_o(clr_valid_o),
		.clr_region_o(clr_region_o), .clr_addr_o(clr_addr_o));
	field_terminals term (.clk_i(clk_i), .load_i(load), .value_i(xnew), .x_o(x_pins_i));
	always #2 clk_i = ~clk_i;
	// Far-side memory: one count per zeroed word outside the default latched windows
	always @(posedge clk_i) begin
		if (clr_valid_o === 1'b1) begin
			if (clr_region_o == RG_INDEX || (clr_region_o < RG_INDEX
				&& (clr_addr_o < WIN[clr_region_o][15:0]
				|| clr_addr_o > WIN[clr_region_o][31:16]))) begin
				n_clr++;
			end else begin
				n_clr += 100000;
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic conclude();
		if (fail_count == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : conclude
	task automatic chk(input logic [255:0] got, input logic [255:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask : chk
	// Classic single Wishbone cycle, held until ack is sampled
	task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		for (int i = 0; i < 20; i++) begin
			@(posedge clk_i);
			if (wb_ack_o === 1'b1) begin
				rd = wb_dat_o;
				wb_cyc_i <= 1'b0;
				wb_stb_i <= 1'b0;
				return;
			end
		end
		fail_count++;
		conclude();
	endtask : bus
	task automatic wait_exec();
		for (int i = 0; i < 60000; i++) begin
			@(posedge clk_i);
			if (exec_o === 1'b1) begin
				return;
			end
		end
		fail_count++;
		conclude();
	endtask : wait_exec
	// Stop request, then the end instruction closes the running scan
	task automatic stop_scan();
		bus(1'b1, ADR_CTRL, 32'h0);
		end_i <= 1'b1;
		@(posedge clk_i);
		end_i <= 1'b0;
		n_scans++;
		repeat (2) @(posedge clk_i);
	endtask : stop_scan
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		chk(y_pins_o, '0);
		bus(1'b0, ADR_CTRL, 32'h0);
		chk(rd, '0);
		// Default latched windows per region, aux to data
		for (int r = 0; r < 6; r++) begin
			bus(1'b0, 8'h20 + 8'(4 * r), 32'h0);
			chk(rd, WIN[r]);
		end
		seed = lfsr(seed);
		start = seed[15:0];
		bus(1'b1, ADR_START, {16'h0, start});
		seed = lfsr(seed);
		xnew <= {8{seed}};
		bus(1'b1, ADR_CTRL, 32'h3);
		wait_exec();
		chk(x_image_o, {8{seed}});
		chk(prog_addr_o, start);
		chk(n_clr, NL_WORDS);
		// Terminals move while the program runs; the image keeps the sampled value
		xnew <= {8{lfsr(seed)}};
		step_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk(x_image_o, {8{seed}});
		seed = lfsr(seed);
		step_i <= 1'b0;
		y_wr_i <= 1'b1;
		y_val_i <= 1'b1;
		y_num_i <= 12'h375;
		y_model[253] = 1'b1;
		@(posedge clk_i);
		chk(prog_addr_o, start + 16'h3);
		y_num_i <= 12'h018;
		@(posedge clk_i);
		y_wr_i <= 1'b0;
		end_i <= 1'b1;
		@(posedge clk_i);
		end_i <= 1'b0;
		n_scans++;
		repeat (3) @(posedge clk_i);
		chk(y_pins_o, y_model);
		chk(x_image_o, {8{seed}});
		stop_scan();
		chk(y_pins_o, '0);
		chk(y_image_o, '0);
		// Window moves: legal, out of range, fixed region, unmapped
		bus(1'b1, 8'h20, 32'h1B580258);
		bus(1'b0, 8'h20, 32'h0);
		chk(rd, 32'h1B580258);
		bus(1'b1, 8'h20, 32'h20000000);
		bus(1'b0, 8'h20, 32'h0);
		chk(rd, 32'h1B580258);
		bus(1'b1, 8'h28, 32'h00050000);
		bus(1'b0, 8'h28, 32'h0);
		chk(rd, 32'h00000001);
		bus(1'b0, 8'h1C, 32'h0);
		chk(rd, '0);
		// Second run with retain: no sweep, fresh input image
		seed = lfsr(seed);
		xnew <= {8{seed}};
		bus(1'b1, ADR_CTRL, 32'h3);
		wait_exec();
		chk(x_image_o, {8{seed}});
		chk(n_clr, NL_WORDS);
		stop_scan();
		// Latched clear flag reads back while its job runs
		bus(1'b1, ADR_CTRL, 32'h20);
		bus(1'b0, ADR_CTRL, 32'h0);
		chk(rd, 32'h20);
		// Scan count as double word and as decimal digits
		bus(1'b0, ADR_SCAN_LO, 32'h0);
		chk(rd, n_scans);
		bus(1'b0, ADR_SCAN_HI, 32'h0);
		chk(rd, 0);
		bus(1'b0, ADR_SCAN_BCD, 32'h0);
		chk(rd, (n_scans / 10) * 16 + n_scans % 10);
		conclude();
	end
endmodule : test_scan_mem_ctrl
`default_nettype wire

// ---- rtl/region_clear_sweep.sv ----
// Module: walks every memory region and issues zeroing strobes per clear job
`timescale 1ns/1ps
`default_nettype none
module region_clear_sweep (
	input  wire logic clk_i,
	input  wire logic rst_i,
	sweep_if.engine   sw
);
	import scan_mem_pkg::*;

	logic        busy_reg;
	region_t     region_reg;
	logic [15:0] addr_reg;
	logic        nl_reg;
	logic        lat_reg;
	logic        fr_reg;
	logic        skip;
	logic        last;
	logic        want;
	logic        latched;
	logic        valid_reg;
	region_t     out_region_reg;
	logic [15:0] out_addr_reg;
	logic        done_reg;

	////////////////////////////////////////////////////////////////////////
	// Decide per address whether the running job zeroes it
	always_comb begin
		latched = is_latched(addr_reg, sw.win_lo[region_reg], sw.win_hi[region_reg]);
		if (region_reg == RG_FILE) begin
			skip = !fr_reg;
			want = fr_reg;
		end else begin
			skip = !(nl_reg || (lat_reg && REGION_LATCHABLE[region_reg]));
			want = (nl_reg && !latched) || (lat_reg && latched);
		end
		last = skip || (addr_reg == REGION_LAST[region_reg]);
	end

	// Walk regions in order, skipping those the job leaves alone
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			busy_reg   <= 1'b0;
			region_reg <= RG_AUX;
			addr_reg   <= 16'h0000;
			nl_reg     <= 1'b0;
			lat_reg    <= 1'b0;
			fr_reg     <= 1'b0;
		end else if (!busy_reg && sw.start) begin
			busy_reg   <= 1'b1;
			region_reg <= RG_AUX;
			addr_reg   <= 16'h0000;
			nl_reg     <= sw.sel_nl;
			lat_reg    <= sw.sel_lat;
			fr_reg     <= sw.sel_fr;
		end else if (busy_reg) begin
			if (last) begin
				addr_reg <= 16'h0000;
				if (region_reg == RG_FILE) begin
					busy_reg <= 1'b0;
				end else begin
					region_reg <= region_t'(region_reg + 3'h1);
				end
			end else begin
				addr_reg <= addr_reg + 16'h0001;
			end
		end
	end

	// Registered strobe outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			valid_reg      <= 1'b0;
			out_region_reg <= RG_AUX;
			out_addr_reg   <= 16'h0000;
			done_reg       <= 1'b0;
		end else begin
			valid_reg      <= busy_reg && !skip && want;
			out_region_reg <= region_reg;
			out_addr_reg   <= addr_reg;
			done_reg       <= busy_reg && last && (region_reg == RG_FILE);
		end
	end

	assign sw.busy       = busy_reg;
	assign sw.done       = done_reg;
	assign sw.clr_valid  = valid_reg;
	assign sw.clr_region = out_region_reg;
	assign sw.clr_addr   = out_addr_reg;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking sw_cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	file_reg_guard_a: assert property (
		sw.clr_valid && sw.clr_region == RG_FILE |-> fr_reg)
		else $error("file register zeroed by a job without restore");
	fixed_nonlatch_a: assert property (
		sw.clr_valid && (sw.clr_region == RG_TIMER || sw.clr_region == RG_INDEX) |-> nl_reg)
		else $error("timer or index zeroed outside a non-latched job");
	window_respect_a: assert property (
		sw.clr_valid && sw.clr_region != RG_FILE && !lat_reg
		|-> !is_latched(sw.clr_addr, sw.win_lo[sw.clr_region], sw.win_hi[sw.clr_region]))
		else $error("latched address zeroed by a non-latched job");
	sweep_done_c: cover property (sw.done && nl_reg);

endmodule : region_clear_sweep
`default_nettype wire

// ---- rtl/scan_mem_ctrl.sv ----
// Module: scan sequencer, I/O images and retention control with Wishbone registers
//
// Decided for this implementation: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module scan_mem_ctrl (
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	input  wire logic [7:0]           wb_adr_i,
	input  wire logic [31:0]          wb_dat_i,
	output logic [31:0]               wb_dat_o,
	input  wire logic [3:0]           wb_sel_i,
	input  wire logic                 wb_we_i,
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	output logic                      wb_ack_o,
	input  wire logic [255:0]         x_pins_i,
	output logic [255:0]              y_pins_o,
	output logic [255:0]              x_image_o,
	output logic [255:0]              y_image_o,
	output logic                      exec_o,
	output logic [15:0]               prog_addr_o,
	input  wire logic                 step_i,
	input  wire logic                 end_i,
	input  wire logic                 y_wr_i,
	input  wire logic [11:0]          y_num_i,
	input  wire logic                 y_val_i,
	output logic                      clr_valid_o,
	output scan_mem_pkg::region_t     clr_region_o,
	output logic [15:0]               clr_addr_o
);
	import scan_mem_pkg::*;

	sweep_if sw ();

	logic                 ack_reg;
	logic [31:0]          rdata_reg;
	logic                 wb_req;
	logic                 wr_ctrl;
	logic                 wr_start;
	logic                 wr_win;
	logic [31:0]          ctrl_word;
	logic [31:0]          wdata;
	logic [2:0]           win_idx;
	logic                 win_ok;
	logic                 restore;
	logic                 set_nl;
	logic                 set_lat;
	logic                 run_reg;
	logic                 s2r_retain_reg;
	logic                 r2s_retain_reg;
	logic [15:0]          start_addr_reg;
	logic [15:0]          win_lo_reg [REGION_N];
	logic [15:0]          win_hi_reg [REGION_N];
	scan_state_t          state_reg;
	logic [15:0]          pc_reg;
	logic [255:0]         x_image_reg;
	logic [255:0]         y_image_reg;
	logic [255:0]         y_pins_reg;
	logic [31:0]          scan_cnt_reg;
	logic [15:0]          scan_bcd_reg;
	logic                 pend_nl_reg;
	logic                 pend_lat_reg;
	logic                 pend_fr_reg;
	logic                 flag_nl_reg;
	logic                 flag_lat_reg;
	logic                 job_nl_reg;
	logic                 job_lat_reg;
	logic                 pend_any;
	logic                 s2r_event;
	logic                 r2s_clear;
	logic                 ev_nl;
	logic                 clear_y;

	////////////////////////////////////////////////////////////////////////
	// Wishbone slave decode
	assign wb_req   = wb_cyc_i && wb_stb_i && !ack_reg;
	assign wr_ctrl  = wb_req && wb_we_i && (wb_adr_i == ADR_CTRL);
	assign wr_start = wb_req && wb_we_i && (wb_adr_i == ADR_START);
	assign wr_win   = wb_req && wb_we_i && (wb_adr_i[7:5] == ADR_WIN_PAGE)
		&& (wb_adr_i[1:0] == 2'h0);
	assign win_idx  = wb_adr_i[4:2];
	assign ctrl_word = {26'h0, flag_lat_reg, flag_nl_reg, 1'b0, r2s_retain_reg,
		s2r_retain_reg, run_reg};
	assign wdata    = merge_bytes(wr_win ? {win_hi_reg[win_idx], win_lo_reg[win_idx]}
		: wr_start ? {16'h0000, start_addr_reg} : ctrl_word, wb_dat_i, wb_sel_i);
	// Window must be ordered, inside the type's range, and not moved mid-sweep
	assign win_ok   = REGION_LATCHABLE[win_idx] && (wdata[15:0] <= wdata[31:16])
		&& (wdata[31:16] <= REGION_LAST[win_idx]) && !sw.busy && !pend_any;
	assign restore  = wr_ctrl && wdata[CTRL_RESTORE];
	assign set_nl   = wr_ctrl && wdata[CTRL_CLR_NL];
	assign set_lat  = wr_ctrl && wdata[CTRL_CLR_LAT];

	// Acknowledge one cycle after the request, drop it the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= wb_req;
		end
	end

	// Read data; unmapped addresses read zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_reg <= 32'h00000000;
		end else if (wb_req) begin
			rdata_reg <= 32'h00000000;
			if (wb_adr_i[7:5] == ADR_WIN_PAGE && wb_adr_i[1:0] == 2'h0) begin
				rdata_reg <= {win_hi_reg[win_idx], win_lo_reg[win_idx]};
			end else begin
				case (wb_adr_i)
					ADR_CTRL:     rdata_reg <= ctrl_word;
					ADR_STATUS:   rdata_reg <= {25'h0, pend_any, sw.busy, state_reg};
					ADR_START:    rdata_reg <= {16'h0000, start_addr_reg};
					ADR_PC:       rdata_reg <= {16'h0000, pc_reg};
					ADR_SCAN_LO:  rdata_reg <= {16'h0000, scan_cnt_reg[15:0]};
					ADR_SCAN_HI:  rdata_reg <= {16'h0000, scan_cnt_reg[31:16]};
					ADR_SCAN_BCD: rdata_reg <= {16'h0000, scan_bcd_reg};
					default:      rdata_reg <= 32'h00000000;
				endcase
			end
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdata_reg;

	////////////////////////////////////////////////////////////////////////
	// Control options; restore brings back the defaults
	always_ff @(posedge clk_i) begin
		if (rst_i || restore) begin
			run_reg        <= 1'b0;
			s2r_retain_reg <= S2R_RETAIN_RST;
			r2s_retain_reg <= R2S_RETAIN_RST;
			start_addr_reg <= START_ADDR_RST;
		end else if (wr_ctrl) begin
			run_reg        <= wdata[CTRL_RUN];
			s2r_retain_reg <= wdata[CTRL_S2R_RETAIN];
			r2s_retain_reg <= wdata[CTRL_R2S_RETAIN];
		end else if (wr_start) begin
			start_addr_reg <= wdata[15:0];
		end
	end

	// Latched windows per region
	always_ff @(posedge clk_i) begin
		if (rst_i || restore) begin
			for (int i = 0; i < REGION_N; i++) begin
				win_lo_reg[i] <= WIN_LO_RST[i];
				win_hi_reg[i] <= WIN_HI_RST[i];
			end
		end else if (wr_win && win_ok) begin
			win_lo_reg[win_idx] <= wdata[15:0];
			win_hi_reg[win_idx] <= wdata[31:16];
		end
	end

	assign sw.win_lo = win_lo_reg;
	assign sw.win_hi = win_hi_reg;

	////////////////////////////////////////////////////////////////////////
	// Clear events
	assign s2r_event = (state_reg == ST_STOP) && run_reg;
	assign r2s_clear = (state_reg == ST_OUTPUT) && !run_reg && !r2s_retain_reg;
	assign ev_nl     = (s2r_event && !s2r_retain_reg) || set_nl || restore;
	assign clear_y   = ev_nl || r2s_clear;
	assign pend_any  = pend_nl_reg || pend_lat_reg || pend_fr_reg;
	assign sw.start  = !sw.busy && pend_any;
	assign sw.sel_nl = pend_nl_reg;
	assign sw.sel_lat = pend_lat_reg;
	assign sw.sel_fr = pend_fr_reg;

	// Pending jobs; a new request wins over the hand-off to the engine
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pend_nl_reg  <= 1'b1;
			pend_lat_reg <= 1'b0;
			pend_fr_reg  <= 1'b0;
		end else begin
			pend_nl_reg  <= ev_nl || (pend_nl_reg && !sw.start);
			pend_lat_reg <= set_lat || restore || (pend_lat_reg && !sw.start);
			pend_fr_reg  <= restore || (pend_fr_reg && !sw.start);
		end
	end

	// Clear flags drop when the job that carried them finishes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flag_nl_reg  <= 1'b0;
			flag_lat_reg <= 1'b0;
			job_nl_reg   <= 1'b0;
			job_lat_reg  <= 1'b0;
		end else begin
			flag_nl_reg  <= set_nl || (flag_nl_reg && !(sw.done && job_nl_reg));
			flag_lat_reg <= set_lat || (flag_lat_reg && !(sw.done && job_lat_reg));
			if (sw.start) begin
				job_nl_reg  <= flag_nl_reg;
				job_lat_reg <= flag_lat_reg;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Scan sequencer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= ST_STOP;
		end else begin
			case (state_reg)
				ST_STOP:   if (run_reg) begin
					state_reg <= ST_CLEAR;
				end
				ST_CLEAR:  if (!run_reg) begin
					state_reg <= ST_STOP;
				end else if (!sw.busy && !pend_any) begin
					state_reg <= ST_SAMPLE;
				end
				ST_SAMPLE: state_reg <= ST_EXEC;
				ST_EXEC:   if (end_i) begin
					state_reg <= ST_OUTPUT;
				end
				ST_OUTPUT: state_reg <= run_reg ? ST_SAMPLE : ST_STOP;
				default:   state_reg <= ST_STOP;
			endcase
		end
	end

	// Program counter: loaded at sampling, advanced per executed step
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pc_reg <= START_ADDR_RST;
		end else if (state_reg == ST_SAMPLE) begin
			pc_reg <= start_addr_reg;
		end else if (state_reg == ST_EXEC && step_i) begin
			pc_reg <= pc_reg + 16'h0001;
		end
	end

	// Input and output images
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			x_image_reg <= '0;
			y_image_reg <= '0;
		end else begin
			if (ev_nl) begin
				x_image_reg <= '0;
			end else if (state_reg == ST_SAMPLE) begin
				x_image_reg <= x_pins_i;
			end
			if (clear_y) begin
				y_image_reg <= '0;
			end else if (state_reg == ST_EXEC && y_wr_i && octal_ok(y_num_i)) begin
				y_image_reg[octal_index(y_num_i)] <= y_val_i;
			end
		end
	end

	// Output terminals refresh after the end instruction
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			y_pins_reg <= '0;
		end else if (clear_y) begin
			y_pins_reg <= '0;
		end else if (state_reg == ST_OUTPUT) begin
			y_pins_reg <= y_image_reg;
		end
	end

	// Scan counters, binary double word and decimal digits
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			scan_cnt_reg <= 32'h00000000;
			scan_bcd_reg <= 16'h0000;
		end else if (state_reg == ST_OUTPUT) begin
			scan_cnt_reg <= scan_cnt_reg + 32'h00000001;
			scan_bcd_reg <= bcd_inc(scan_bcd_reg);
		end
	end

	assign y_pins_o     = y_pins_reg;
	assign x_image_o    = x_image_reg;
	assign y_image_o    = y_image_reg;
	assign exec_o       = (state_reg == ST_EXEC);
	assign prog_addr_o  = pc_reg;
	assign clr_valid_o  = sw.clr_valid;
	assign clr_region_o = sw.clr_region;
	assign clr_addr_o   = sw.clr_addr;

	region_clear_sweep u_sweep (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.sw    (sw.engine)
	);

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	input_sample_a: assert property (
		state_reg == ST_SAMPLE && !ev_nl |=> state_reg == ST_EXEC
		&& x_image_reg == $past(x_pins_i))
		else $error("input image not sampled at scan start");
	input_frozen_a: assert property (
		state_reg == ST_EXEC && !ev_nl |=> $stable(x_image_reg))
		else $error("input image changed during execution");
	pc_start_a: assert property (
		state_reg == ST_SAMPLE |=> prog_addr_o == $past(start_addr_reg))
		else $error("program did not start at start address");
	output_refresh_a: assert property (
		state_reg == ST_OUTPUT && !clear_y |=> y_pins_o == $past(y_image_reg))
		else $error("output terminals not refreshed at end");
	s2r_clear_a: assert property (
		s2r_event && !s2r_retain_reg |=> y_image_reg == '0 && pend_nl_reg
		&& state_reg == ST_CLEAR)
		else $error("stop to run did not clear non-latched regions");
	s2r_retain_a: assert property (
		s2r_event && s2r_retain_reg && !set_nl && !set_lat && !pend_any && !sw.busy
		|=> $stable(y_image_reg) && !pend_nl_reg ##1 state_reg == ST_SAMPLE)
		else $error("stop to run with retain disturbed memory");
	r2s_output_a: assert property (
		state_reg == ST_OUTPUT && !run_reg && !r2s_retain_reg
		|=> y_image_reg == '0 && y_pins_o == '0 && state_reg == ST_STOP)
		else $error("run to stop did not clear output image");
	option_default_a: assert property (
		$fell(rst_i) |-> !s2r_retain_reg && !r2s_retain_reg && pend_nl_reg)
		else $error("options not at default after reset");
	aux_window_a: assert property (
		$fell(rst_i) |-> win_lo_reg[RG_AUX] == 16'h1770 && win_hi_reg[RG_STEP] == 16'h03FF)
		else $error("default auxiliary or step window wrong");
	data_window_a: assert property (
		$fell(rst_i) |-> win_lo_reg[RG_DATA] == 16'h4E20 && win_lo_reg[RG_CNT] == 16'h01C0)
		else $error("default counter or data window wrong");
	latched_flag_a: assert property (
		set_lat && state_reg == ST_STOP && !ev_nl |=> pend_lat_reg && $stable(y_image_reg))
		else $error("latched clear flag not queued or output touched");

	scan_loop_c: cover property (state_reg == ST_OUTPUT ##1 state_reg == ST_SAMPLE);
	restore_c: cover property (restore ##[1:20] sw.busy);
	r2s_keep_c: cover property (state_reg == ST_OUTPUT && !run_reg && r2s_retain_reg);

endmodule : scan_mem_ctrl
`default_nettype wire

// ---- rtl/scan_mem_pkg.sv ----
// Package: constants, types and helpers for the scan memory retention block
package scan_mem_pkg;

	localparam int REGION_N = 8;
	localparam int IO_BITS  = 256;

	// Memory regions swept by the clear engine
	typedef enum logic [2:0] {
		RG_AUX   = 3'h0,
		RG_STEP  = 3'h1,
		RG_TIMER = 3'h2,
		RG_CNT   = 3'h3,
		RG_WIDE  = 3'h4,
		RG_DATA  = 3'h5,
		RG_INDEX = 3'h6,
		RG_FILE  = 3'h7
	} region_t;

	// Scan sequencer states
	typedef enum logic [4:0] {
		ST_STOP   = 5'h01,
		ST_CLEAR  = 5'h02,
		ST_SAMPLE = 5'h04,
		ST_EXEC   = 5'h08,
		ST_OUTPUT = 5'h10
	} scan_state_t;

	// Last address of each region
	localparam logic [15:0] REGION_LAST [REGION_N] = '{16'h1FFF, 16'h07FF, 16'h01FF,
		16'h01FF, 16'h00FF, 16'h752F, 16'h0009, 16'hFFFF};
	// Latched window reset values; timers and index registers hold an empty window
	localparam logic [15:0] WIN_LO_RST [REGION_N] = '{16'h1770, 16'h0200, 16'h0001,
		16'h01C0, 16'h0080, 16'h4E20, 16'h0001, 16'h0000};
	localparam logic [15:0] WIN_HI_RST [REGION_N] = '{16'h1FFF, 16'h03FF, 16'h0000,
		16'h01FF, 16'h00FF, 16'h752F, 16'h0000, 16'hFFFF};
	// Regions whose window software may move
	localparam logic [7:0]  REGION_LATCHABLE = 8'h3B;

	// Register byte offsets
	localparam logic [7:0]  ADR_CTRL     = 8'h00;
	localparam logic [7:0]  ADR_STATUS   = 8'h04;
	localparam logic [7:0]  ADR_START    = 8'h08;
	localparam logic [7:0]  ADR_PC       = 8'h0C;
	localparam logic [7:0]  ADR_SCAN_LO  = 8'h10;
	localparam logic [7:0]  ADR_SCAN_HI  = 8'h14;
	localparam logic [7:0]  ADR_SCAN_BCD = 8'h18;
	localparam logic [2:0]  ADR_WIN_PAGE = 3'h1;

	// Control register fields
	localparam int CTRL_RUN        = 0;
	localparam int CTRL_S2R_RETAIN = 1;
	localparam int CTRL_R2S_RETAIN = 2;
	localparam int CTRL_RESTORE    = 3;
	localparam int CTRL_CLR_NL     = 4;
	localparam int CTRL_CLR_LAT    = 5;

	// Control reset values
	localparam logic        S2R_RETAIN_RST = 1'b0;
	localparam logic        R2S_RETAIN_RST = 1'b0;
	localparam logic [15:0] START_ADDR_RST = 16'h0000;

	// Address inside an inclusive latched window
	function automatic logic is_latched(input logic [15:0] a, input logic [15:0] lo,
		input logic [15:0] hi);
		return (a >= lo) && (a <= hi);
	endfunction : is_latched

	// Three octal digits held one per nibble, at most 377
	function automatic logic octal_ok(input logic [11:0] num);
		return (num[11:10] == 2'h0) && !num[7] && !num[3];
	endfunction : octal_ok

	function automatic logic [7:0] octal_index(input logic [11:0] num);
		return {num[9:8], num[6:4], num[2:0]};
	endfunction : octal_index

	// Four-digit decimal increment, one digit per nibble
	function automatic logic [15:0] bcd_inc(input logic [15:0] v);
		logic [15:0] r;
		logic        c;
		r = v;
		c = 1'b1;
		for (int i = 0; i < 4; i++) begin
			if (c) begin
				if (r[i*4 +: 4] == 4'h9) begin
					r[i*4 +: 4] = 4'h0;
				end else begin
					r[i*4 +: 4] = r[i*4 +: 4] + 4'h1;
					c = 1'b0;
				end
			end
		end
		return r;
	endfunction : bcd_inc

	// Byte-lane merge for bus writes
	function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge_bytes

endpackage : scan_mem_pkg

// ---- rtl/sweep_if.sv ----
// Interface: clear job request and sweep results between sequencer and engine
`timescale 1ns/1ps
`default_nettype none
interface sweep_if;
	import scan_mem_pkg::*;
	logic          start;
	logic          sel_nl;
	logic          sel_lat;
	logic          sel_fr;
	logic [15:0]   win_lo [REGION_N];
	logic [15:0]   win_hi [REGION_N];
	logic          busy;
	logic          done;
	logic          clr_valid;
	region_t       clr_region;
	logic [15:0]   clr_addr;

	modport ctrl (output start, sel_nl, sel_lat, sel_fr, win_lo, win_hi,
		input busy, done, clr_valid, clr_region, clr_addr);
	modport engine (input start, sel_nl, sel_lat, sel_fr, win_lo, win_hi,
		output busy, done, clr_valid, clr_region, clr_addr);
endinterface : sweep_if
`default_nettype wire
